// file: isf_status_flags.sv
// status flags, clock stretch and register slave of the two-wire interface
// ****************
// How it works
// - event flag is the or of all event flags, drops when all cleared
// - ten-bit header flag: set after header; cleared by sequence, stop flag, off
// - direction valid with byte-done; cleared with it, stop, arbitration, off
// - bus-busy set on any start, cleared on stop, even when off
// - transmit: byte-done after ack clock; cleared by status read then data write
// - receive: byte-done after ack clock; cleared by status read then data read
// - clock held low while byte-done, address match or start-sent is set
// - address match on own or broadcast address; cleared by status read, off
// - master role set on made start; cleared by stop, arbitration loss, off
// - start-sent set on made start; cleared by status read then data write
// - master address acknowledged flag set when address byte is acknowledged
// - ack failure set on missing ack; cleared by second status read, off
// - stop flag set on stop after acknowledge as slave; cleared by read, off
// - arbitration loss sets flag, drops master role; cleared by read, off
// - bus error on start or stop inside a byte; cleared by read, off
// - misplaced start adds arbitration loss; stop on ack pulse adds ack failure
// - broadcast match with enable sets flag; cleared by stop or off
// - event flags except master address acknowledged raise the interrupt request when interrupts are enabled
// - flag set during its clearing status read is reported but raises no request
// - top two bits of second status read as zero
// - interface off clears both status registers except bus-busy and releases the clock line
// ****************
//
// Design decision made here: the AXI4-Lite slave port.
module isf_status_flags import isf_pkg::*; (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// axi4-lite write
	input logic [ADDR_W-1:0] awaddr,
	input logic awvalid,
	output logic awready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	input logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input logic bready,
	// axi4-lite read
	input logic [ADDR_W-1:0] araddr,
	input logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input logic rready,
	// bus lines
	input logic scl_line,
	input logic sda_line,
	output logic scl_drive,
	output logic scl_oe,
	// byte engine
	input isf_evt_t evt,
	input logic [7:0] rx_byte,
	output logic [7:0] tx_byte,
	output logic data_written,
	output logic data_taken,
	output logic irq
);
	// ****************
	// decode
	// ****************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, IDX_CTRL) | hit(a, IDX_SR1) | hit(a, IDX_SR2) | hit(a, IDX_OWN_LO)
			| hit(a, IDX_OWN_HI) | hit(a, IDX_DATA) | hit(a, IDX_BCAST);
	endfunction : mapped

	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_have_q, w_have_q;
	logic [7:0] ctrl_q, own_lo_q, own_hi_q, bcast_q;
	logic btf_q, tra_q, sb_q, ten_bit_header_sent_q, slave_addr_match_q, msl_q, busy_q;
	logic af_q, stop_seen_q, arbitration_lost_q, misplaced_condition_q, broadcast_match_q, addr_acked_master_q;
	logic armed_q, hdr_ok_q, slave_acked_q;
	logic [1:0] lines;
	logic start_det, stop_det;

	// ****************
	// line watcher
	// ****************
	isf_line_watch u_watch (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw({sda_line, scl_line}),
		.level_q(lines),
		.start_q(start_det),
		.stop_q(stop_det)
	);

	// ****************
	// access strobes
	// ****************
	logic wr_go, rd_go, wr0;
	logic on, ten, gc_en;
	logic rd_sr1, rd_sr2, rd_data, wr_data, seq_wr, seq_rd;
	assign wr_go = aw_have_q & w_have_q & ~bvalid;
	assign rd_go = arvalid & arready;
	assign wr0 = wr_go & w_strb_q[0];
	assign on = ctrl_q[CTRL_ON];
	assign ten = own_hi_q[OWN_HI_TEN];
	assign gc_en = ctrl_q[CTRL_GC_EN];
	assign rd_sr1 = rd_go & hit(araddr, IDX_SR1);
	assign rd_sr2 = rd_go & hit(araddr, IDX_SR2);
	assign rd_data = rd_go & hit(araddr, IDX_DATA);
	assign wr_data = wr0 & hit(aw_addr_q, IDX_DATA);
	assign seq_wr = armed_q & wr_data;
	assign seq_rd = armed_q & rd_data;

	// ****************
	// address compare
	// ****************
	logic a_ok, hdr_hit, own_hit, gc_hit;
	assign a_ok = evt.addr_byte != ADDR_IGNORED;
	assign hdr_hit = evt.addr_byte[7:3] == TEN_HDR && evt.addr_byte[2:1] == own_hi_q[2:1];
	assign own_hit = a_ok & (ten ? (hdr_ok_q & evt.addr_byte == own_lo_q)
		: evt.addr_byte[7:1] == own_lo_q[7:1]);
	assign gc_hit = a_ok & gc_en & evt.addr_byte[7:1] == bcast_q[7:1];

	// ****************
	// set terms, all gated by the enable
	// ****************
	logic misplaced, set_btf, set_sb, set_ten_bit_header_sent, set_slave_addr_match, set_broadcast_match, set_addr_acked_master;
	logic set_misplaced_condition, set_arbitration_lost, set_af, set_stop_seen, clr_btf;
	assign misplaced = on & (evt.byte_active | evt.ack_pulse) & (start_det | stop_det);
	assign set_btf = on & (evt.tx_ack_clock | evt.rx_ack_clock);
	assign set_sb = on & evt.start_made;
	assign set_ten_bit_header_sent = on & ten & evt.header_sent;
	assign set_slave_addr_match = on & evt.addr_valid & (own_hit | gc_hit);
	assign set_broadcast_match = on & evt.addr_valid & gc_hit;
	assign set_addr_acked_master = on & msl_q & evt.addr_acked;
	assign set_misplaced_condition = misplaced;
	assign set_arbitration_lost = on & (evt.arb_lost & msl_q | misplaced & start_det);
	assign set_af = on & (evt.no_ack | evt.ack_pulse & stop_det);
	assign set_stop_seen = on & stop_det & ~msl_q & slave_acked_q;
	// transmit clears on write, receive on read
	assign clr_btf = tra_q ? seq_wr : seq_rd;

	// ****************
	// write and read channels
	// ****************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awready <= 1'b1;
			aw_addr_q <= '0;
		end else if (awvalid & awready) begin
			aw_have_q <= 1'b1;
			awready <= 1'b0;
			aw_addr_q <= awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wready <= 1'b1;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid & wready) begin
			w_have_q <= 1'b1;
			wready <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// status read values carry event flags being set this cycle; role, direction and busy bits are registered only
	logic evf_q, evf_now;
	logic [7:0] sr1_val, sr2_val, rd_val;
	assign evf_q = btf_q | slave_addr_match_q | sb_q | ten_bit_header_sent_q | af_q | stop_seen_q | arbitration_lost_q | misplaced_condition_q | addr_acked_master_q;
	assign evf_now = evf_q | set_btf | set_slave_addr_match | set_sb | set_ten_bit_header_sent | set_af | set_stop_seen
		| set_arbitration_lost | set_misplaced_condition | set_addr_acked_master;
	assign sr1_val = {evf_now, ten_bit_header_sent_q | set_ten_bit_header_sent, tra_q, busy_q, btf_q | set_btf,
		slave_addr_match_q | set_slave_addr_match, msl_q, sb_q | set_sb};
	assign sr2_val = {2'b00, addr_acked_master_q | set_addr_acked_master, af_q | set_af, stop_seen_q | set_stop_seen,
		arbitration_lost_q | set_arbitration_lost, misplaced_condition_q | set_misplaced_condition, broadcast_match_q | set_broadcast_match};

	always_comb begin
		rd_val = 8'h00;
		if (hit(araddr, IDX_CTRL)) rd_val = ctrl_q;
		if (hit(araddr, IDX_SR1)) rd_val = sr1_val;
		if (hit(araddr, IDX_SR2)) rd_val = sr2_val;
		if (hit(araddr, IDX_OWN_LO)) rd_val = own_lo_q;
		if (hit(araddr, IDX_OWN_HI)) rd_val = own_hi_q;
		if (hit(araddr, IDX_DATA)) rd_val = rx_byte;
		if (hit(araddr, IDX_BCAST)) rd_val = bcast_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (rd_go) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h000000, rd_val};
			rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid & rready) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
		end
	end

	// ****************
	// software registers
	// ****************
	// off also drops interrupt and broadcast enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr0 & hit(aw_addr_q, IDX_CTRL)) begin
			ctrl_q <= w_data_q[CTRL_ON] ? w_data_q[7:0] & CTRL_MASK : CTRL_RST;
		end
	end

	// own high and broadcast addresses are frozen while the interface is on; own low stays writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			own_lo_q <= OWN_RST;
			own_hi_q <= OWN_RST;
			bcast_q <= BCAST_RST;
		end else begin
			if (wr0 & hit(aw_addr_q, IDX_OWN_LO)) own_lo_q <= w_data_q[7:0];
			if (wr0 & ~on & hit(aw_addr_q, IDX_OWN_HI)) own_hi_q <= w_data_q[7:0] & OWN_HI_MASK;
			if (wr0 & ~on & hit(aw_addr_q, IDX_BCAST)) bcast_q <= w_data_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_byte <= 8'h00;
			data_written <= 1'b0;
			data_taken <= 1'b0;
		end else begin
			if (wr_data) tx_byte <= w_data_q[7:0];
			data_written <= wr_data;
			data_taken <= rd_data;
		end
	end

	// ****************
	// sequence and address tracking
	// ****************
	// a first-status read arms the data access that completes a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_q <= 1'b0;
		end else if (!on) begin
			armed_q <= 1'b0;
		end else if (rd_sr1) begin
			armed_q <= 1'b1;
		end else if (wr_data | rd_data) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hdr_ok_q <= 1'b0;
		end else if (!on | start_det | stop_det) begin
			hdr_ok_q <= 1'b0;
		end else if (evt.addr_valid) begin
			hdr_ok_q <= ten & hdr_hit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slave_acked_q <= 1'b0;
		end else if (!on | start_det | stop_det) begin
			slave_acked_q <= 1'b0;
		end else if ((set_btf | set_slave_addr_match) & ~msl_q) begin
			slave_acked_q <= 1'b1;
		end
	end

	// ****************
	// first status flags
	// ****************
	// bus tracking ignores the enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
		end else if (stop_det) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			btf_q <= 1'b0;
		end else if (set_btf) begin
			btf_q <= 1'b1;
		end else if (clr_btf | evt.dma_done) begin
			btf_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			tra_q <= 1'b0;
		end else if (set_btf) begin
			tra_q <= evt.dir_send;
		end else if (clr_btf | evt.dma_done | set_stop_seen | set_arbitration_lost) begin
			tra_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			sb_q <= 1'b0;
		end else if (set_sb) begin
			sb_q <= 1'b1;
		end else if (seq_wr) begin
			sb_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			ten_bit_header_sent_q <= 1'b0;
		end else if (set_ten_bit_header_sent) begin
			ten_bit_header_sent_q <= 1'b1;
		end else if (seq_wr | set_stop_seen) begin
			ten_bit_header_sent_q <= 1'b0;
		end
	end

	// the clearing read wins: a late set is only reported
	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			slave_addr_match_q <= 1'b0;
		end else if (rd_sr1) begin
			slave_addr_match_q <= 1'b0;
		end else if (set_slave_addr_match) begin
			slave_addr_match_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on) begin
			msl_q <= 1'b0;
		end else if (stop_det | set_arbitration_lost) begin
			msl_q <= 1'b0;
		end else if (evt.start_made) begin
			msl_q <= 1'b1;
		end
	end

	// ****************
	// second status flags
	// ****************
	always_ff @(posedge aclk) begin
		if (!aresetn | !on | rd_sr2) begin
			af_q <= 1'b0;
			stop_seen_q <= 1'b0;
			arbitration_lost_q <= 1'b0;
			misplaced_condition_q <= 1'b0;
			addr_acked_master_q <= 1'b0;
		end else begin
			if (set_af) af_q <= 1'b1;
			if (set_stop_seen) stop_seen_q <= 1'b1;
			if (set_arbitration_lost) arbitration_lost_q <= 1'b1;
			if (set_misplaced_condition) misplaced_condition_q <= 1'b1;
			if (set_addr_acked_master) addr_acked_master_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn | !on | stop_det) begin
			broadcast_match_q <= 1'b0;
		end else if (set_broadcast_match) begin
			broadcast_match_q <= 1'b1;
		end
	end

	// ****************
	// clock stretch and interrupt
	// ****************
	// error flags never stretch, so the bus can recover
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_oe <= 1'b0;
			scl_drive <= 1'b0;
		end else begin
			scl_oe <= on & (btf_q | slave_addr_match_q | sb_q);
			scl_drive <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= ctrl_q[CTRL_IRQ_EN] & (btf_q | ten_bit_header_sent_q | slave_addr_match_q | sb_q | af_q | stop_seen_q
				| arbitration_lost_q | misplaced_condition_q);
		end
	end

	// level is kept for visibility of a stuck line only
	logic unused_lines;
	assign unused_lines = ^lines;
endmodule : isf_status_flags

// file: isf_pkg.sv
// shared constants and types for the two-wire status-flag block
package isf_pkg;
	// ****************
	// register map
	// ****************
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_CTRL = 8'hf0;
	localparam logic [7:0] IDX_SR1 = 8'hf1;
	localparam logic [7:0] IDX_SR2 = 8'hf2;
	localparam logic [7:0] IDX_OWN_LO = 8'hf4;
	localparam logic [7:0] IDX_OWN_HI = 8'hf5;
	localparam logic [7:0] IDX_DATA = 8'hf6;
	localparam logic [7:0] IDX_BCAST = 8'hf7;
	// ****************
	// field positions
	// ****************
	localparam int CTRL_IRQ_EN = 0;
	localparam int CTRL_GC_EN = 4;
	localparam int CTRL_ON = 5;
	localparam int OWN_HI_TEN = 5;
	// ****************
	// reset values and write masks
	// ****************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OWN_RST = 8'h00;
	localparam logic [7:0] BCAST_RST = 8'ha0;
	localparam logic [7:0] CTRL_MASK = 8'h31;
	localparam logic [7:0] OWN_HI_MASK = 8'h26;
	// ****************
	// bus constants
	// ****************
	localparam logic [7:0] ADDR_IGNORED = 8'h01;
	localparam logic [4:0] TEN_HDR = 5'h1e;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SYNC_STAGES = 3;
	// ****************
	// byte-engine events, same clock
	// ****************
	typedef struct packed {
		logic start_made;
		logic header_sent;
		logic tx_ack_clock;
		logic rx_ack_clock;
		logic dir_send;
		logic addr_valid;
		logic [7:0] addr_byte;
		logic addr_acked;
		logic no_ack;
		logic arb_lost;
		logic byte_active;
		logic ack_pulse;
		logic dma_done;
	} isf_evt_t;
endpackage : isf_pkg

// file: isf_line_watch.sv
// synchronises the two bus lines and finds start and stop conditions
module isf_line_watch import isf_pkg::*; (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// raw lines, bit 0 clock, bit 1 data
	input logic [1:0] raw,
	// filtered levels and condition pulses
	output logic [1:0] level_q,
	output logic start_q,
	output logic stop_q
);
	logic [1:0] agree;
	logic [1:0] new_lvl;

	// ****************
	// three-stage synchronisers
	// ****************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			logic [SYNC_STAGES-1:0] sync_q;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync_q <= '1;
				end else begin
					sync_q <= {sync_q[SYNC_STAGES-2:0], raw[g]};
				end
			end
			// only stages two and three are looked at
			assign agree[g] = sync_q[1] == sync_q[2];
			assign new_lvl[g] = agree[g] ? sync_q[1] : level_q[g];
		end
	endgenerate

	// ****************
	// levels and conditions
	// ****************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_q <= 2'h3;
			start_q <= 1'b0;
			stop_q <= 1'b0;
		end else begin
			level_q <= new_lvl;
			start_q <= level_q[0] & new_lvl[0] & level_q[1] & ~new_lvl[1];
			stop_q <= level_q[0] & new_lvl[0] & ~level_q[1] & new_lvl[1];
		end
	end
endmodule : isf_line_watch

// file: isf_status_flags_properties.sv
// concurrent checks on the ports of the status-flag block
module isf_status_flags_props import isf_pkg::*; (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// register bus
	input logic [ADDR_W-1:0] awaddr,
	input logic awvalid,
	input logic awready,
	input logic wvalid,
	input logic wready,
	input logic [1:0] bresp,
	input logic bvalid,
	input logic bready,
	input logic [ADDR_W-1:0] araddr,
	input logic arvalid,
	input logic arready,
	input logic [31:0] rdata,
	input logic rvalid,
	input logic rready,
	// bus and engine side
	input logic scl_drive,
	input logic scl_oe,
	input isf_evt_t evt,
	input logic data_written,
	input logic data_taken
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [ADDR_W-1:0] ra_q;
	wire cause = evt.start_made | evt.tx_ack_clock | evt.rx_ack_clock | evt.addr_valid;
	// only the last taken read address matters for the answer
	always_ff @(posedge aclk) begin
		if (arvalid && arready) ra_q <= araddr;
	end
	// ****************
	// assertions
	// ****************
	a_drive_low: assert property (scl_drive == 1'h0)
		else $error("clock line value not low");
	a_stretch_cause: assert property ($rose(scl_oe) |-> $past(cause, 2))
		else $error("clock stretch without a stretching event");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed before taken");
	a_sr2_top_zero: assert property (rvalid && ra_q == {2'h0, IDX_SR2, 2'h0} |->
		rdata[7:6] == 2'h0) else $error("second status top bits set");
	a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_data_taken: assert property (arvalid && arready && araddr == {2'h0, IDX_DATA, 2'h0}
		|-> ##[1:2] data_taken) else $error("data read not passed on");
	a_data_written: assert property (awvalid && awready && wvalid && wready
		&& awaddr == {2'h0, IDX_DATA, 2'h0} |-> ##2 data_written)
		else $error("data write not passed on");
	c_write: cover property (bvalid && bready);
	c_stretch: cover property ($rose(scl_oe));
	c_sr2_read: cover property (rvalid && ra_q == {2'h0, IDX_SR2, 2'h0});
endmodule : isf_status_flags_props

bind isf_status_flags isf_status_flags_props u_props (.aclk, .aresetn, .awaddr, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
	.rvalid, .rready, .scl_drive, .scl_oe, .evt, .data_written, .data_taken);

// file: isf_bus_agent.sv
// behavioural other master on the two-wire bus
module isf_bus_agent (
	// wired clock line
	input logic scl_in,
	// open-drain values, 1 = released
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	// start: data falls while clock high, clock then held low inside frame
	task automatic start_cond();
		#62.5 sda_o = 1'h0;
		#62.5 scl_o = 1'h0;
	endtask : start_cond
	// stop: waits out a stretched clock like a real master
	task automatic stop_cond();
		#62.5 sda_o = 1'h0;
		scl_o = 1'h1;
		wait (scl_in);
		#62.5 sda_o = 1'h1;
	endtask : stop_cond
endmodule : isf_bus_agent

// file: tb_isf_status_flags.sv
// self-checking testbench of the status-flag block
module tb_isf_status_flags import isf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] A_SR1 = {2'h0, IDX_SR1, 2'h0};
	localparam logic [11:0] A_SR2 = {2'h0, IDX_SR2, 2'h0};
	localparam logic [11:0] A_OWN = {2'h0, IDX_OWN_LO, 2'h0};
	localparam logic [11:0] A_OWNH = {2'h0, IDX_OWN_HI, 2'h0};
	localparam logic [11:0] A_DATA = {2'h0, IDX_DATA, 2'h0};
	localparam logic [11:0] A_BC = {2'h0, IDX_BCAST, 2'h0};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h1;
	logic [7:0] rx_byte = 8'h6b;
	logic awready, wready, bvalid, arready, rvalid, scl_drive, scl_oe;
	logic data_written, data_taken, irq, scl_o, sda_o;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] tx_byte;
	isf_evt_t evt = '0;
	isf_evt_t lv = '0;
	// pulled-up clock wire shared with the stretching device
	wire scl_w = scl_o & !scl_oe;
	int err_count = 0;
	int cmp_count = 0;
	initial forever #5 aclk = ~aclk;
	isf_status_flags dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .scl_line(scl_w), .sda_line(sda_o), .scl_drive, .scl_oe,
		.evt, .rx_byte, .tx_byte, .data_written, .data_taken, .irq);
	isf_bus_agent agent (.scl_in(scl_w), .scl_o, .sda_o);
	// ****************
	// shared tasks
	// ****************
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// waits for the answer as long as it takes; only the watchdog ends a hang
	task automatic wr(logic [11:0] a, logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask : wr
	task automatic rd(logic [11:0] a, output logic [31:0] v);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		v = rdata;
		rready <= 1'h0;
	endtask : rd
	task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(nm, e, v);
	endtask : rdc
	// one-cycle engine pulse on top of the held levels
	task automatic fire(isf_evt_t e);
		@(posedge aclk);
		evt <= e | lv;
		@(posedge aclk);
		evt <= lv;
		repeat (3) @(posedge aclk);
	endtask : fire
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		logic [31:0] v;
		rdc("sr1", A_SR1, 32'h0);
		rdc("sr2", A_SR2, 32'h0);
		rdc("bcast", A_BC, 32'ha0);
		rd(12'h3e0, v);
		chk("unmapped_rresp", 32'h2, {30'h0, rresp});
		agent.start_cond();
		repeat (12) @(posedge aclk);
		rdc("busy_off", A_SR1, 32'h10);
		agent.stop_cond();
		repeat (12) @(posedge aclk);
		rdc("idle_off", A_SR1, 32'h0);
		$display("test reset and busy done");
	endtask : t_reset
	task automatic t_master();
		logic [1:0] r;
		wr(A_OWN, 8'h52, r);
		// ten-bit mode is only writable while off; the header flag needs it
		wr(A_OWNH, 8'h20, r);
		wr(A_CTRL, 8'h31, r);
		wr(A_CTRL, 8'h31, r);
		fire('{start_made: 1'h1, default: '0});
		chk("stretch", 32'h1, {31'h0, scl_oe});
		chk("irq", 32'h1, {31'h0, irq});
		rdc("sr1_start", A_SR1, 32'h83);
		wr(A_DATA, 8'ha5, r);
		repeat (3) @(posedge aclk);
		rdc("sr1_addr", A_SR1, 32'h02);
		chk("tx_byte", 32'ha5, {24'h0, tx_byte});
		chk("released", 32'h0, {31'h0, scl_oe});
		fire('{addr_acked: 1'h1, default: '0});
		rdc("sr1_ack", A_SR1, 32'h82);
		rdc("sr2_ack", A_SR2, 32'h20);
		rdc("sr2_clr", A_SR2, 32'h0);
		lv.dir_send = 1'h1;
		fire('{tx_ack_clock: 1'h1, default: '0});
		rdc("sr1_tx", A_SR1, 32'haa);
		wr(A_DATA, 8'h3c, r);
		lv = '0;
		rdc("sr1_txclr", A_SR1, 32'h02);
		fire('{header_sent: 1'h1, default: '0});
		rdc("sr1_hdr", A_SR1, 32'hc2);
		wr(A_DATA, 8'h11, r);
		rdc("sr1_hdrclr", A_SR1, 32'h02);
		fire('{arb_lost: 1'h1, no_ack: 1'h1, default: '0});
		rdc("sr1_arb", A_SR1, 32'h80);
		rdc("sr2_arb", A_SR2, 32'h14);
		rdc("sr2_arbclr", A_SR2, 32'h0);
		rdc("sr1_none", A_SR1, 32'h0);
		$display("test master flow done");
	endtask : t_master
	task automatic t_slave();
		// ten-bit slave: header byte arms, second byte must equal the low address
		fire('{addr_valid: 1'h1, addr_byte: 8'hf0, default: '0});
		fire('{addr_valid: 1'h1, addr_byte: 8'h52, default: '0});
		rdc("sr1_match", A_SR1, 32'h84);
		rdc("sr1_mclr", A_SR1, 32'h0);
		fire('{rx_ack_clock: 1'h1, default: '0});
		rdc("sr1_rx", A_SR1, 32'h88);
		rdc("data", A_DATA, 32'h6b);
		rdc("sr1_rxclr", A_SR1, 32'h0);
		agent.start_cond();
		repeat (12) @(posedge aclk);
		fire('{addr_valid: 1'h1, addr_byte: 8'ha0, default: '0});
		rdc("sr1_gc", A_SR1, 32'h94);
		rdc("sr2_gc", A_SR2, 32'h01);
		agent.stop_cond();
		repeat (12) @(posedge aclk);
		rdc("sr1_stop", A_SR1, 32'h80);
		rdc("sr2_stop", A_SR2, 32'h08);
		rdc("sr1_quiet", A_SR1, 32'h0);
		$display("test slave flow done");
	endtask : t_slave
	task automatic t_misplaced();
		logic [31:0] v;
		logic [1:0] r;
		lv.byte_active = 1'h1;
		@(posedge aclk);
		evt <= lv;
		agent.start_cond();
		repeat (12) @(posedge aclk);
		rdc("sr2_mstart", A_SR2, 32'h06);
		lv = '0;
		lv.ack_pulse = 1'h1;
		@(posedge aclk);
		evt <= lv;
		agent.stop_cond();
		repeat (12) @(posedge aclk);
		rd(A_SR2, v);
		chk("sr2_mstop", 32'h12, v & 32'h12);
		lv = '0;
		evt <= lv;
		fire('{start_made: 1'h1, default: '0});
		wr(A_CTRL, 8'h00, r);
		repeat (3) @(posedge aclk);
		chk("off_release", 32'h0, {31'h0, scl_oe});
		rdc("sr1_off", A_SR1, 32'h0);
		wr(12'h3e0, 8'h55, r);
		chk("unmapped_bresp", 32'h2, {30'h0, r});
		$display("test misplaced and disable done");
	endtask : t_misplaced
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_master();
		t_slave();
		t_misplaced();
		final_report();
	end
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#400us;
		err_count++;
		final_report();
	end
endmodule : tb_isf_status_flags
